// ==== hwd_pkg.sv ====
/*
  hwd_pkg: shared constants for the hardware watchdog timer.
  assumes core_clk is the oscillator clock, one machine cycle is twelve oscillator periods.
*/
package hwd_pkg;

  localparam int          CNT_W          = 14;
  localparam logic [13:0] CNT_TERMINAL   = 14'h3FFF;
  localparam logic [13:0] CNT_RESET      = 14'h0000;

  localparam logic [7:0]  ADDR_SERVICE   = 8'hA6;
  localparam logic [7:0]  ADDR_PRESCALE  = 8'hA7;
  localparam logic [7:0]  KEY_FIRST      = 8'h1E;
  localparam logic [7:0]  KEY_SECOND     = 8'hE1;
  localparam logic [7:0]  RDATA_SERVICE  = 8'h00;

  localparam int          PRESC_W        = 7;
  localparam int          PSEL_W         = 3;
  localparam logic [2:0]  PSEL_RESET     = 3'h0;
  localparam logic [6:0]  PRESC_RESET    = 7'h00;

  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          OSC_PERIOD_PS  = 5000;
  localparam int          OSC_PER_MC     = 12;
  localparam int          MC_CYCLES      = (OSC_PER_MC * OSC_PERIOD_PS + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
  localparam int          PULSE_OSC      = 96;
  localparam int          PULSE_CYCLES_I = (PULSE_OSC * OSC_PERIOD_PS + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
  localparam logic [7:0]  PULSE_CYCLES   = 8'(PULSE_CYCLES_I);
  localparam logic [7:0]  PULSE_IDLE     = 8'h00;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b01,
    KEY_HALF = 2'b10
  } hwd_key_type;

endpackage : hwd_pkg

// ==== hwd_cycle_div.sv ====
/*
  hwd_cycle_div: divides the oscillator clock into a one-cycle machine-cycle enable.
  assumes the oscillator runs continuously while rstn is high.
*/
`timescale 1ns/1ps
module hwd_cycle_div #(
  parameter int DIV = hwd_pkg::MC_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  output logic      tick_q
);

  logic [7:0] div_q;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end
    else if (div_q == 8'(DIV - 1))
    begin
      div_q  <= 8'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q  <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

endmodule : hwd_cycle_div

// ==== hwd_watch_timer.sv ====
/*
  hwd_watch_timer: watchdog with key-armed 14-bit counter, 2^7 prescaler and reset pulse.
  assumes a one-cycle special-function write/read strobe from the core on core_clk;
  rst_pin_* is the two-way reset pin, resolved by the pad outside this module.
*/
`timescale 1ns/1ps
module hwd_watch_timer #(
  parameter int MC_DIV = hwd_pkg::MC_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       sfr_wr_en,
  input  wire logic       sfr_rd_en,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata_q,
  input  wire logic       rst_pin_in,
  output logic            rst_pin_out_q,
  output logic            rst_pin_oe_q,
  output logic            sys_reset_q,
  output logic            watch_active_q
);

  hwd_pkg::hwd_key_type  key_q;
  logic [13:0]           cnt_q;
  logic [6:0]            presc_q;
  logic [2:0]            psel_q;
  logic [7:0]            pulse_q;
  logic                  pin_meta_q;
  logic                  pin_sync_q;
  logic [1:0]            own_q;
  logic                  mc_tick;
  logic                  wr_service;
  logic                  service_ok;
  logic                  presc_full;
  logic                  cnt_step;
  logic                  ovf_fire;
  logic                  pin_reset;
  logic                  busy;

  // presc_q low bits all ones means 2^sel machine cycles have passed
  function automatic logic presc_wrap(input logic [6:0] p, input logic [2:0] s);
    logic [6:0] mask;
    mask = 7'((8'h01 << s) - 8'h01);
    presc_wrap = ((p & mask) == mask);
  endfunction : presc_wrap

  hwd_cycle_div #(
    .DIV (MC_DIV)
  ) u_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick_q   (mc_tick)
  );

  // external reset pin, synchronised; own drive stays masked two cycles past the
  // pulse, since the synchroniser still holds our own high level that long
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      own_q      <= 2'b00;
    end
    else
    begin
      pin_meta_q <= rst_pin_in;
      pin_sync_q <= pin_meta_q;
      own_q      <= {own_q[0], rst_pin_oe_q};
    end
  end

  assign busy       = (pulse_q != hwd_pkg::PULSE_IDLE);
  assign pin_reset  = pin_sync_q && !rst_pin_oe_q && !(|own_q);
  assign wr_service = sfr_wr_en && (sfr_addr == hwd_pkg::ADDR_SERVICE) && !busy;
  assign service_ok = wr_service && (key_q == hwd_pkg::KEY_HALF)
                      && (sfr_wdata == hwd_pkg::KEY_SECOND);
  assign presc_full = presc_wrap(presc_q, psel_q);
  assign cnt_step   = watch_active_q && mc_tick && presc_full;
  assign ovf_fire   = watch_active_q && (cnt_q == hwd_pkg::CNT_TERMINAL);

  // key sequence tracker
  always_ff @(posedge core_clk)
  begin
    if (!rstn || pin_reset || ovf_fire)
      key_q <= hwd_pkg::KEY_IDLE;
    else if (wr_service)
    begin
      case (key_q)
        hwd_pkg::KEY_IDLE:
          key_q <= (sfr_wdata == hwd_pkg::KEY_FIRST) ? hwd_pkg::KEY_HALF : hwd_pkg::KEY_IDLE;
        hwd_pkg::KEY_HALF:
          key_q <= hwd_pkg::KEY_IDLE;
        default:
          key_q <= hwd_pkg::KEY_IDLE;
      endcase
    end
  end

  // armed flag: only resets turn it off, the key can only set it
  always_ff @(posedge core_clk)
  begin
    if (!rstn || pin_reset || ovf_fire)
      watch_active_q <= 1'b0;
    else if (service_ok)
      watch_active_q <= 1'b1;
  end

  // prescale select, readable so software can confirm it
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      psel_q <= hwd_pkg::PSEL_RESET;
    else if (sfr_wr_en && (sfr_addr == hwd_pkg::ADDR_PRESCALE) && !busy)
      psel_q <= sfr_wdata[2:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn || !watch_active_q || service_ok)
      presc_q <= hwd_pkg::PRESC_RESET;
    else if (mc_tick)
      presc_q <= presc_full ? hwd_pkg::PRESC_RESET : presc_q + 7'h01;
  end

  // counter has no software load path at all
  always_ff @(posedge core_clk)
  begin
    if (!rstn || pin_reset || ovf_fire || !watch_active_q)
      cnt_q <= hwd_pkg::CNT_RESET;
    else if (service_ok)
      cnt_q <= hwd_pkg::CNT_RESET;
    else if (cnt_step)
      cnt_q <= cnt_q + 14'h0001;
  end

  // reset pulse, counted on the oscillator clock itself
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pulse_q       <= hwd_pkg::PULSE_IDLE;
      rst_pin_out_q <= 1'b0;
      rst_pin_oe_q  <= 1'b0;
      sys_reset_q   <= 1'b0;
    end
    else if (ovf_fire)
    begin
      pulse_q       <= hwd_pkg::PULSE_CYCLES;
      rst_pin_out_q <= 1'b1;
      rst_pin_oe_q  <= 1'b1;
      sys_reset_q   <= 1'b1;
    end
    else
    begin
      pulse_q       <= busy ? pulse_q - 8'h01 : pulse_q;
      rst_pin_out_q <= (pulse_q > 8'h01);
      rst_pin_oe_q  <= (pulse_q > 8'h01);
      sys_reset_q   <= (pulse_q > 8'h01);
    end
  end

  // reads never expose the counter or the key state
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      sfr_rdata_q <= hwd_pkg::RDATA_SERVICE;
    else if (sfr_rd_en && (sfr_addr == hwd_pkg::ADDR_PRESCALE))
      sfr_rdata_q <= {5'h00, psel_q};
    else
      sfr_rdata_q <= hwd_pkg::RDATA_SERVICE;
  end

  // helper: length of each reset pulse
  logic [7:0] plen_q;
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      plen_q <= 8'h00;
    else if (rst_pin_out_q)
      plen_q <= plen_q + 8'h01;
    else
      plen_q <= 8'h00;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_idle_after_reset;
    $past(!rstn) |-> !watch_active_q && (cnt_q == hwd_pkg::CNT_RESET);
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset) else $error("armed after reset");

  property p_arm;
    service_ok && !ovf_fire && !pin_reset |=> watch_active_q && (cnt_q == 14'h0000);
  endproperty
  a_arm: assert property (p_arm) else $error("key pair did not arm and clear");

  property p_step;
    cnt_step && !ovf_fire && !service_ok && !pin_reset |=> cnt_q == $past(cnt_q) + 14'h0001;
  endproperty
  a_step: assert property (p_step) else $error("counter missed a step");

  property p_stay_armed;
    watch_active_q && !ovf_fire && !pin_reset |=> watch_active_q;
  endproperty
  a_stay_armed: assert property (p_stay_armed) else $error("watchdog disarmed");

  property p_overflow;
    ovf_fire |=> sys_reset_q && rst_pin_oe_q && !watch_active_q;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow gave no reset");

  property p_service_clears;
    watch_active_q && service_ok && !ovf_fire && !pin_reset |=> cnt_q == 14'h0000;
  endproperty
  a_service_clears: assert property (p_service_clears) else $error("service did not clear");

  property p_read_blank;
    sfr_rd_en && (sfr_addr == hwd_pkg::ADDR_SERVICE) |=> sfr_rdata_q == 8'h00;
  endproperty
  a_read_blank: assert property (p_read_blank) else $error("service key read not blank");

  property p_cnt_moves;
    (cnt_q != $past(cnt_q)) |-> (cnt_q == 14'h0000) || (cnt_q == $past(cnt_q) + 14'h0001);
  endproperty
  a_cnt_moves: assert property (p_cnt_moves) else $error("counter loaded");

  property p_pulse_len;
    $fell(rst_pin_out_q) |-> plen_q == 8'h60;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

  property p_presc_hold;
    watch_active_q && mc_tick && !presc_full && !service_ok && !ovf_fire && !pin_reset
      |=> $stable(cnt_q);
  endproperty
  a_presc_hold: assert property (p_presc_hold) else $error("prescaler let a step through");

  property p_bad_key;
    wr_service && (key_q == hwd_pkg::KEY_HALF) && (sfr_wdata != hwd_pkg::KEY_SECOND)
      && !ovf_fire && !pin_reset |=> (key_q == hwd_pkg::KEY_IDLE) && $stable(watch_active_q);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key changed state");

  property p_cv_arm;
    service_ok && !watch_active_q;
  endproperty
  c_cv_arm: cover property (p_cv_arm);

  property p_cv_service;
    service_ok && watch_active_q && (cnt_q != 14'h0000);
  endproperty
  c_cv_service: cover property (p_cv_service);

  property p_cv_ovf;
    $fell(rst_pin_out_q);
  endproperty
  c_cv_ovf: cover property (p_cv_ovf);

endmodule : hwd_watch_timer

// ==== testbench.sv ====
/*
  testbench: self-checking bench for hwd_watch_timer, register read checks, a table of key writes, then hand tests.
  assumes a 200 MHz core_clk and a reset pad pulled low when nobody drives it.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", nm, (e), (g)); end end
module testbench;
  typedef struct {logic [7:0] a; logic [7:0] d; logic act;} hwd_row_type;
  // a short machine cycle keeps both full-length timeout runs within the cycle budget
  localparam int TB_MC_DIV = 2;
  logic       core_clk  = 1'b0;
  logic       rstn      = 1'b0;
  logic       sfr_wr_en = 1'b0;
  logic       sfr_rd_en = 1'b0;
  logic [7:0] sfr_addr  = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       ext_rst   = 1'b0;
  wire logic  rst_pin_in;
  logic [7:0] sfr_rdata_q;
  logic       rst_pin_out_q;
  logic       rst_pin_oe_q;
  logic       sys_reset_q;
  logic       watch_active_q;
  int         mismatches = 0;
  int         compares   = 0;
  int         n;
  int         w;
  int         lo;
  int         hi;
  logic [7:0] v;
  // a mis-ordered pair must leave the timer off; once on, nothing in software turns it off
  hwd_row_type rows [13] = '{
    '{8'hA6, 8'h1E, 1'b0}, '{8'hA6, 8'h55, 1'b0}, '{8'hA6, 8'hE1, 1'b0},
    '{8'hA6, 8'h1E, 1'b0}, '{8'hA6, 8'h1E, 1'b0}, '{8'hA6, 8'hE1, 1'b0},
    '{8'hA5, 8'h1E, 1'b0}, '{8'hA6, 8'hE1, 1'b0}, '{8'hA6, 8'h1E, 1'b0},
    '{8'hA7, 8'h00, 1'b0}, '{8'hA6, 8'hE1, 1'b1}, '{8'hA6, 8'h00, 1'b1},
    '{8'hA5, 8'h00, 1'b1}};

  // pad level: the pin drives when enabled, otherwise the pull-down or an outside reset
  assign rst_pin_in = rst_pin_oe_q ? rst_pin_out_q : ext_rst;

  hwd_watch_timer #(
    .MC_DIV         (TB_MC_DIV)
  ) i_dut (
    .core_clk       (core_clk),
    .rstn           (rstn),
    .sfr_wr_en      (sfr_wr_en),
    .sfr_rd_en      (sfr_rd_en),
    .sfr_addr       (sfr_addr),
    .sfr_wdata      (sfr_wdata),
    .sfr_rdata_q    (sfr_rdata_q),
    .rst_pin_in     (rst_pin_in),
    .rst_pin_out_q  (rst_pin_out_q),
    .rst_pin_oe_q   (rst_pin_oe_q),
    .sys_reset_q    (sys_reset_q),
    .watch_active_q (watch_active_q)
  );

  always #2.5 core_clk = ~core_clk;

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick

  // strobe is dropped for one cycle between writes, so no edge sees it set twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr_en = 1'b1;
    tick(1);
    sfr_wr_en = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    sfr_addr  = a;
    sfr_rd_en = 1'b1;
    tick(1);
    sfr_rd_en = 1'b0;
    q         = sfr_rdata_q;
    tick(1);
  endtask : rd

  task automatic print_verdict;
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    tick(10);
    rstn = 1'b1;
    tick(1);
    `CHK("active_after_reset", 1'b0, watch_active_q)
    `CHK("pin_oe_after_reset", 1'b0, rst_pin_oe_q)
    wr(hwd_pkg::ADDR_PRESCALE, 8'h05);
    rd(hwd_pkg::ADDR_PRESCALE, v);
    `CHK("prescale_read", 8'h05, v)
    wr(hwd_pkg::ADDR_PRESCALE, 8'h00);
    rd(hwd_pkg::ADDR_SERVICE, v);
    `CHK("service_read", hwd_pkg::RDATA_SERVICE, v)
    rd(8'h55, v);
    `CHK("unmapped_read", 8'h00, v)
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      `CHK("active_row", rows[i].act, watch_active_q)
    end
    // service part way through, so an overflow timed from arming would come early
    tick(2000 * TB_MC_DIV);
    wr(hwd_pkg::ADDR_SERVICE, hwd_pkg::KEY_FIRST);
    wr(hwd_pkg::ADDR_SERVICE, hwd_pkg::KEY_SECOND);
    lo = (int'(hwd_pkg::CNT_TERMINAL) - 1) * TB_MC_DIV;
    hi = int'(hwd_pkg::CNT_TERMINAL) * TB_MC_DIV + 4;
    n  = 0;
    while (sys_reset_q !== 1'b1 && n <= hi)
    begin
      tick(1);
      n++;
    end
    if (n > hi)
      mismatches++;
    `CHK("overflow_not_early", 1'b1, n >= lo)
    `CHK("active_off_on_ovf", 1'b0, watch_active_q)
    w = 0;
    v = 8'h00;
    while (sys_reset_q === 1'b1 && w < 200)
    begin
      if (rst_pin_out_q !== 1'b1 || rst_pin_oe_q !== 1'b1)
        v = 8'h01;
      w++;
      tick(1);
    end
    `CHK("pin_driven_high", 8'h00, v)
    `CHK("pulse_len", hwd_pkg::PULSE_CYCLES, 8'(w))
    `CHK("pin_released", 1'b0, rst_pin_oe_q)
    // arm right after the pulse with divide-by-two; the undivided timeout passes unharmed
    wr(hwd_pkg::ADDR_PRESCALE, 8'h01);
    wr(hwd_pkg::ADDR_SERVICE, hwd_pkg::KEY_FIRST);
    wr(hwd_pkg::ADDR_SERVICE, hwd_pkg::KEY_SECOND);
    `CHK("rearmed", 1'b1, watch_active_q)
    tick(int'(hwd_pkg::CNT_TERMINAL) * TB_MC_DIV + 3000);
    `CHK("prescale_slows", 1'b1, watch_active_q)
    // an outside reset on the pad must also disarm
    ext_rst = 1'b1;
    tick(4);
    ext_rst = 1'b0;
    tick(2);
    `CHK("pin_reset_off", 1'b0, watch_active_q)
    wr(hwd_pkg::ADDR_SERVICE, hwd_pkg::KEY_FIRST);
    wr(hwd_pkg::ADDR_SERVICE, hwd_pkg::KEY_SECOND);
    `CHK("rearmed_after_pin", 1'b1, watch_active_q)
    rstn = 1'b0;
    tick(10);
    rstn = 1'b1;
    tick(1);
    `CHK("core_reset_off", 1'b0, watch_active_q)
    print_verdict();
  end
endmodule : testbench
